// >>> hdl/boot_cfg_access.sv
// Purpose: serial command logic that reads and rewrites the boot configuration register
// Assumes: link clocked by sck in mode 0; chip select high for at least 4 clk periods
// Notes:   link side on sck, register and update timer on clk
`timescale 1ns/1ps
module boot_cfg_access #(
   parameter int UPD_CYCLES = boot_cfg_pkg::UPDATE_CYCLES
) (
   input  wire logic        clk,
   input  wire logic        rst_b,
   input  wire logic        sck,
   input  wire logic        cs_b,
   input  wire logic [3:0]  io_in,
   output logic      [3:0]  io_out,
   output logic      [3:0]  io_oe_b,
   input  wire logic        four_line_command_mode,
   output logic             write_in_progress,
   output logic             write_enable_latch,
   output logic             boot_stream_enable,
   output logic      [3:0]  boot_delay_count,
   output logic      [26:0] boot_start_address
);

   // ---------------- link side, sck domain ----------------
   logic [7:0]  cnt_reg;
   logic [7:0]  cnt_next;
   logic [31:0] rx_reg;
   logic [31:0] rx_next;
   logic [7:0]  op_reg;
   logic        hdr_reg;
   logic        hdr_next;
   logic        over_reg;
   logic        over_next;
   logic        quad_m_reg;
   logic        quad_reg;
   logic        wip_m_reg;
   logic        wip_s_reg;
   logic        wel_m_reg;
   logic        wel_s_reg;
   logic [31:0] wdata_reg;
   logic [31:0] wdata_next;
   logic        wr_ok_reg;
   logic        wr_ok_next;
   logic        latch_ok_reg;
   logic        latch_ok_next;
   logic        seq_reg;
   logic        seq_next;
   logic [7:0]  op_next;

   wire  [7:0]  step      = quad_reg ? 8'h04 : 8'h01;
   wire         first_bit = (cnt_reg == 8'h00) && !hdr_reg;
   wire         at_opcode = (cnt_next == boot_cfg_pkg::OPCODE_BITS);
   wire         at_data   = (cnt_next == boot_cfg_pkg::WRITE_FRAME_BITS);

   // opcode decode; the latch-set test looks at the byte still arriving
   wire         is_rd_cmd    = (op_reg == boot_cfg_pkg::BOOT_CFG_READ_CMD);
   wire         is_wr_cmd    = (op_reg == boot_cfg_pkg::BOOT_CFG_WRITE_CMD);
   wire         is_st_cmd    = (op_reg == boot_cfg_pkg::STATUS_READ_CMD);
   wire         is_latch_cmd = (rx_next[7:0] == boot_cfg_pkg::WRITE_LATCH_SET_CMD);

   // step follows the synced mode, so a mode change mid-frame still changes the step from the third sck edge after it on
   assign cnt_next  = cnt_reg + step;
   assign rx_next   = quad_reg ? {rx_reg[27:0], io_in} : {rx_reg[30:0], io_in[0]};
   assign hdr_next  = hdr_reg | at_opcode;
   // any bit beyond the 40th spoils the write for good
   assign over_next = over_reg | (cnt_reg == boot_cfg_pkg::WRITE_FRAME_BITS);

   // the opcode is captured once, on the edge that completes it
   assign op_next       = (at_opcode && !hdr_reg) ? rx_next[7:0] : op_reg;
   assign wdata_next    = at_data ? rx_next : wdata_reg;
   // a write qualifies only if the 40th bit was the last one seen
   assign wr_ok_next    = at_data && !over_next && hdr_reg && is_wr_cmd;
   assign latch_ok_next = at_opcode && !hdr_reg && is_latch_cmd;
   // toggles once per frame that has at least one sck edge
   assign seq_next      = first_bit ? !seq_reg : seq_reg;

   // frame state, cleared by chip select high since sck may stand still between frames
   always_ff @(posedge sck or posedge cs_b) begin
      if (cs_b) begin
         cnt_reg <= 8'h00;
         rx_reg  <= 32'h0000_0000;
      end else begin
         cnt_reg <= cnt_next;
         rx_reg  <= rx_next;
      end
   end

   always_ff @(posedge sck or posedge cs_b) begin
      if (cs_b) begin
         op_reg   <= 8'h00;
         hdr_reg  <= 1'b0;
         over_reg <= 1'b0;
      end else begin
         op_reg   <= op_next;
         hdr_reg  <= hdr_next;
         over_reg <= over_next;
      end
   end

   // frame results must outlive chip select, so they are not cleared by it
   always_ff @(posedge sck or negedge rst_b) begin
      if (!rst_b) begin
         wdata_reg <= 32'h0000_0000;
      end else begin
         wdata_reg <= wdata_next;
      end
   end

   // the clk side reads these only after chip select has settled high
   always_ff @(posedge sck or negedge rst_b) begin
      if (!rst_b) begin
         wr_ok_reg    <= 1'b0;
         latch_ok_reg <= 1'b0;
         seq_reg      <= 1'b0;
      end else begin
         wr_ok_reg    <= wr_ok_next;
         latch_ok_reg <= latch_ok_next;
         seq_reg      <= seq_next;
      end
   end

   // level synchronisers into the link domain; only the second flop is read
   always_ff @(posedge sck or negedge rst_b) begin
      if (!rst_b) begin
         quad_m_reg <= 1'b0;
         quad_reg   <= 1'b0;
      end else begin
         quad_m_reg <= four_line_command_mode;
         quad_reg   <= quad_m_reg;
      end
   end

   // status lags by two sck edges, just in time for the first status nibble in four-line mode
   always_ff @(posedge sck or negedge rst_b) begin
      if (!rst_b) begin
         wip_m_reg <= 1'b0;
         wip_s_reg <= 1'b0;
      end else begin
         wip_m_reg <= write_in_progress;
         wip_s_reg <= wip_m_reg;
      end
   end

   always_ff @(posedge sck or negedge rst_b) begin
      if (!rst_b) begin
         wel_m_reg <= 1'b0;
         wel_s_reg <= 1'b0;
      end else begin
         wel_m_reg <= write_enable_latch;
         wel_s_reg <= wel_m_reg;
      end
   end

   // ---------------- read-out, falling sck ----------------
   logic [31:0] cfg_reg;

   // byte order on the wire: low byte first, each byte msb first
   wire  [31:0] rd_stream = {cfg_reg[7:0], cfg_reg[15:8], cfg_reg[23:16], cfg_reg[31:24]};
   wire  [4:0]  rd_idx    = cnt_reg[4:0] - boot_cfg_pkg::READ_PHASE;
   wire  [31:0] rd_shift  = rd_stream >> {~rd_idx[4:2], 2'b00};
   wire         rd_bit    = rd_stream[~rd_idx];
   wire  [7:0]  st_byte   = {6'h00, wel_s_reg, wip_s_reg};
   wire         st_bit    = st_byte[~cnt_reg[2:0]];
   wire  [3:0]  st_nib    = cnt_reg[2] ? st_byte[3:0] : st_byte[7:4];
   // config reads are driven only while the synced status shows no update running
   wire         do_cfg    = hdr_reg && !wip_s_reg && is_rd_cmd;
   wire         do_st     = hdr_reg && is_st_cmd;
   wire  [3:0]  nib_out   = do_st ? st_nib : rd_shift[3:0];
   wire         bit_out   = do_st ? st_bit : rd_bit;
   wire  [3:0]  out_next  = quad_reg ? nib_out : {2'b00, bit_out, 1'b0};
   wire  [3:0]  oe_next   = !(do_cfg || do_st) ? 4'hF : (quad_reg ? 4'h0 : 4'hD);

   // cs_b high frees the lines at once, without waiting for an sck edge
   always_ff @(negedge sck or posedge cs_b) begin
      if (cs_b) begin
         io_out <= 4'h0;
      end else begin
         io_out <= out_next;
      end
   end

   always_ff @(negedge sck or posedge cs_b) begin
      if (cs_b) begin
         io_oe_b <= 4'hF;
      end else begin
         io_oe_b <= oe_next;
      end
   end

   // ---------------- register side, clk domain ----------------
   logic       cs_m_reg;
   logic       cs_s_reg;
   logic       cs_d_reg;
   logic       seen_reg;
   logic       wip_reg;
   logic       wel_reg;
   logic       wip_next;
   logic       wel_next;
   logic       seen_next;
   logic [31:0] cfg_next;
   logic [15:0] upd_cnt_reg;
   logic [15:0] upd_cnt_next;
   boot_cfg_pkg::upd_state_t state_reg;
   boot_cfg_pkg::upd_state_t state_next;

   // frame results are quiet while chip select is high, so the synced rise qualifies them
   wire cs_rise   = cs_s_reg && !cs_d_reg;
   wire new_frame = cs_rise && (seq_reg != seen_reg);
   wire idle      = (state_reg == boot_cfg_pkg::UPD_IDLE);
   wire commit    = new_frame && idle && wr_ok_reg && wel_reg;
   wire latch_set = new_frame && idle && latch_ok_reg;
   wire upd_done  = !idle && (upd_cnt_reg == 16'h0000);
   wire [31:0] wr_value = {wdata_reg[7:0], wdata_reg[15:8], wdata_reg[23:16],
                           wdata_reg[31:24]};

   // set and clear never meet: commit needs idle, completion needs busy
   assign wip_next  = commit ? 1'b1 : (upd_done ? 1'b0 : wip_reg);
   assign wel_next  = (latch_set || wel_reg) && !upd_done;
   assign seen_next = cs_rise ? seq_reg : seen_reg;
   // the new image shows at once; reads are held off while busy instead
   assign cfg_next  = commit ? wr_value : cfg_reg;

   always_comb begin
      state_next   = state_reg;
      upd_cnt_next = upd_cnt_reg;
      unique case (state_reg)
         boot_cfg_pkg::UPD_IDLE: begin
            if (commit) begin
               state_next   = boot_cfg_pkg::UPD_BUSY;
               upd_cnt_next = 16'(UPD_CYCLES - 1);
            end
         end
         boot_cfg_pkg::UPD_BUSY: begin
            if (upd_done) begin
               state_next = boot_cfg_pkg::UPD_IDLE;
            end else begin
               upd_cnt_next = upd_cnt_reg - 16'h0001;
            end
         end
      endcase
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         cs_m_reg <= 1'b1;
         cs_s_reg <= 1'b1;
         cs_d_reg <= 1'b1;
      end else begin
         cs_m_reg <= cs_b;
         cs_s_reg <= cs_m_reg;
         cs_d_reg <= cs_s_reg;
      end
   end

   // update timer; the count is loaded at commit and runs down to zero
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         state_reg   <= boot_cfg_pkg::UPD_IDLE;
         upd_cnt_reg <= 16'h0000;
      end else begin
         state_reg   <= state_next;
         upd_cnt_reg <= upd_cnt_next;
      end
   end

   // remembers which frame was already handled, so a quiet deselect does nothing
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         seen_reg <= 1'b0;
      end else begin
         seen_reg <= seen_next;
      end
   end

   // config outputs are slices of this flop, so they change only at a commit
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         cfg_reg <= boot_cfg_pkg::CFG_RESET;
      end else begin
         cfg_reg <= cfg_next;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         wip_reg <= 1'b0;
      end else begin
         wip_reg <= wip_next;
      end
   end

   // write enable latch: set by its own frame, dropped when an update ends
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         wel_reg <= 1'b0;
      end else begin
         wel_reg <= wel_next;
      end
   end

   assign write_in_progress  = wip_reg;
   assign write_enable_latch = wel_reg;
   assign boot_stream_enable = cfg_reg[boot_cfg_pkg::ENABLE_BIT];
   assign boot_delay_count   = cfg_reg[boot_cfg_pkg::DELAY_LSB +: boot_cfg_pkg::DELAY_W];
   assign boot_start_address = cfg_reg[boot_cfg_pkg::ADDR_LSB +: boot_cfg_pkg::ADDR_W];

endmodule

// >>> hdl/boot_cfg_pkg.sv
// Purpose: shared constants for the boot configuration register command logic
// Assumes: serial link in clock mode 0, opcodes shifted most significant bit first
// Notes:   field layout, status opcodes and update time are free choices
package boot_cfg_pkg;

   localparam logic [7:0]  BOOT_CFG_READ_CMD   = 8'h14;
   localparam logic [7:0]  BOOT_CFG_WRITE_CMD  = 8'h15;
   localparam logic [7:0]  WRITE_LATCH_SET_CMD = 8'h06;
   localparam logic [7:0]  STATUS_READ_CMD     = 8'h05;

   localparam int          REG_W               = 32;
   localparam logic [31:0] CFG_RESET           = 32'h0000_0000;
   localparam int          ENABLE_BIT          = 0;
   localparam int          DELAY_LSB           = 1;
   localparam int          DELAY_W             = 4;
   localparam int          ADDR_LSB            = 5;
   localparam int          ADDR_W              = 27;

   localparam int          WIP_BIT             = 0;
   localparam int          WEL_BIT             = 1;

   localparam logic [7:0]  OPCODE_BITS         = 8'h08;
   localparam logic [7:0]  WRITE_FRAME_BITS    = 8'h28;
   localparam logic [4:0]  READ_PHASE          = 5'h08;

   localparam int          CLK_PERIOD_NS       = 40;
   localparam int          UPDATE_TIME_NS      = 4000;
   localparam int          UPDATE_CYCLES       = (UPDATE_TIME_NS + CLK_PERIOD_NS - 1)
                                                 / CLK_PERIOD_NS;

   typedef enum logic {UPD_IDLE, UPD_BUSY} upd_state_t;

endpackage

// >>> tb/boot_cfg_access_chk.sv
// Purpose: port checks for the boot config command block
// Assumes: one clk domain for status and config outputs
// Notes:   link side seen only through cs_b and io_oe_b
`timescale 1ns/1ps
module boot_cfg_access_chk #(
   parameter int UPD_CYCLES = 4
) (
   input wire logic        clk,
   input wire logic        rst_b,
   input wire logic        sck,
   input wire logic        cs_b,
   input wire logic [3:0]  io_in,
   input wire logic [3:0]  io_out,
   input wire logic [3:0]  io_oe_b,
   input wire logic        four_line_command_mode,
   input wire logic        write_in_progress,
   input wire logic        write_enable_latch,
   input wire logic        boot_stream_enable,
   input wire logic [3:0]  boot_delay_count,
   input wire logic [26:0] boot_start_address
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   logic [7:0] busy_cnt;
   always_ff @(posedge clk or negedge rst_b)
      if (!rst_b) busy_cnt <= 8'h00;
      else busy_cnt <= write_in_progress ? busy_cnt + 8'h01 : 8'h00;
   sequence commit_s;
      $rose(write_in_progress);
   endsequence
   a_busy_length: assert property ($fell(write_in_progress) |->
      busy_cnt + 1 >= UPD_CYCLES && busy_cnt <= UPD_CYCLES) else $error("busy time off");
   a_busy_bounded: assert property (commit_s |-> ##[1:1000] !write_in_progress)
      else $error("update never ends");
   a_latch_drops: assert property ($fell(write_in_progress) |-> !write_enable_latch)
      else $error("latch kept after update");
   a_latch_held: assert property (write_in_progress |-> write_enable_latch)
      else $error("latch lost during update");
   a_commit_latch: assert property (commit_s |-> $past(write_enable_latch))
      else $error("commit without latch");
   a_commit_cs: assert property (commit_s |-> cs_b)
      else $error("commit inside a frame");
   a_cfg_commit_only: assert property (!$rose(write_in_progress) |->
      $stable({boot_stream_enable, boot_delay_count, boot_start_address}))
      else $error("config changed outside commit");
   a_idle_release: assert property (cs_b |-> io_oe_b == 4'hF)
      else $error("driving while deselected");
   a_drive_width: assert property (!cs_b && io_oe_b != 4'hF |->
      io_oe_b == (four_line_command_mode ? 4'h0 : 4'hD)) else $error("wrong lines driven");
endmodule

// >>> tb/host_link_model.sv
// Purpose: host serial controller issuing frames to the command block
// Assumes: clock mode 0, sck low and stopped between frames
// Notes:   released data lines show the inverse of their last value
`timescale 1ns/1ps
module host_link_model (
   output logic            sck,
   output logic            cs_b,
   output logic      [3:0] io_in,
   input  wire logic [3:0] io_out,
   input  wire logic       quad
);
   initial begin
      sck = 1'b0;
      cs_b = 1'b1;
      io_in = 4'hA;
   end
   task automatic frame(input logic [7:0] op, input logic [31:0] wd, input int nd,
                        input int nr, output logic [63:0] r);
      logic [39:0] s;
      s = {op, wd[7:0], wd[15:8], wd[23:16], wd[31:24]};
      r = 64'h0;
      #3.3 cs_b = 1'b0;
      for (int i = 0; i < 8 + nd + nr; i += (quad ? 4 : 1)) begin
         if (i < 8 + nd)
            io_in = quad ? s[39 - i -: 4] : {~io_in[3:1], s[39 - i]};
         else
            io_in = ~io_in;
         #6 sck = 1'b1;
         if (i >= 8 + nd)
            r = quad ? {r[59:0], io_out} : {r[62:0], io_out[1]};
         #6 sck = 1'b0;
      end
      #6 cs_b = 1'b1;
      io_in = ~io_in;
      // deselect time long enough for the clk side to take the frame
      #200;
   endtask
endmodule

// >>> tb/boot_cfg_access_tb.sv
// Purpose: self-checking bench for the boot config command block
// Assumes: update time shortened through UPD_CYCLES
// Notes:   frames come from host_link_model on an unrelated 12 ns link clock
`timescale 1ns/1ps
module boot_cfg_access_tb;
   logic clk, rst_b, four_line_command_mode, sck, cs_b, write_in_progress, write_enable_latch;
   logic boot_stream_enable;
   logic [3:0]  io_in, io_out, io_oe_b, boot_delay_count;
   logic [26:0] boot_start_address;
   logic [63:0] r;
   int          error_cnt, check_count;
   boot_cfg_access #(.UPD_CYCLES(40)) i_boot_cfg_access (.clk, .rst_b, .sck, .cs_b, .io_in,
      .io_out, .io_oe_b, .four_line_command_mode, .write_in_progress, .write_enable_latch,
      .boot_stream_enable, .boot_delay_count, .boot_start_address);
   host_link_model i_host_link_model (.sck, .cs_b, .io_in, .io_out, .quad(four_line_command_mode));
   always #20 clk = ~clk;
   task automatic chk(input string n, input logic [63:0] seen, exp);
      check_count++;
      if (seen !== exp) begin
         error_cnt++;
         $display("MISMATCH %s expected %h seen %h", n, exp, seen);
      end
   endtask
   task automatic fr(input logic [7:0] op, input logic [31:0] wd, input int nd, nr);
      @(negedge clk);
      i_host_link_model.frame(op, wd, nd, nr, r);
   endtask
   function automatic logic [31:0] sw(input logic [31:0] x);
      return {x[7:0], x[15:8], x[23:16], x[31:24]};
   endfunction
   task automatic t_write(input logic [31:0] d);
      fr(boot_cfg_pkg::WRITE_LATCH_SET_CMD, 32'h0, 0, 0);
      chk("latch", write_enable_latch, 1'b1);
      fr(8'h15, d, 32, 0);
      chk("busy", write_in_progress, 1'b1);
      chk("fields", {boot_start_address, boot_delay_count, boot_stream_enable}, d);
      fr(boot_cfg_pkg::STATUS_READ_CMD, 32'h0, 0, 8);
      chk("status", r[7:0], 8'h03);
      for (int k = 0; k < 200 && write_in_progress; k++) @(negedge clk);
      chk("done", {write_in_progress, write_enable_latch}, 2'b00);
      fr(8'h14, 32'h0, 0, 64);
      chk("word0", sw(r[63:32]), d);
      chk("word1", sw(r[31:0]), d);
   endtask
   // short and over-long writes must both be thrown away
   task automatic t_short(input logic [31:0] d);
      fr(boot_cfg_pkg::WRITE_LATCH_SET_CMD, 32'h0, 0, 0);
      fr(8'h15, ~d, 24, 0);
      fr(8'h15, ~d, 32, 4);
      chk("short", {write_in_progress, write_enable_latch, boot_start_address,
         boot_delay_count, boot_stream_enable}, {2'b01, d});
   endtask
   task automatic summarize();
      $display("checks %0d mismatches %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   initial begin
      clk = 1'b0;
      rst_b = 1'b0;
      four_line_command_mode = 1'b0;
      error_cnt = 0;
      check_count = 0;
      repeat (16) @(negedge clk);
      rst_b = 1'b1;
      fr(8'h15, 32'hA5A5_A5A5, 32, 0);
      chk("refused", {write_in_progress, write_enable_latch, boot_start_address,
         boot_delay_count, boot_stream_enable}, 34'h0);
      t_write(32'h8765_432B);
      t_short(32'h8765_432B);
      @(negedge clk);
      four_line_command_mode = 1'b1;
      // dummy frame lets the mode reach the link side
      fr(8'hFF, 32'h0, 0, 0);
      t_write(32'h1234_5670);
      t_short(32'h1234_5670);
      summarize();
   end
   initial begin
      #100000;
      error_cnt++;
      summarize();
   end
endmodule
bind boot_cfg_access boot_cfg_access_chk #(.UPD_CYCLES(UPD_CYCLES)) i_boot_cfg_access_chk (
   .clk, .rst_b, .sck, .cs_b, .io_in, .io_out, .io_oe_b, .four_line_command_mode,
   .write_in_progress, .write_enable_latch, .boot_stream_enable, .boot_delay_count,
   .boot_start_address);
